// file: src/lpm_cfg.svh
// constants for the low power mode controller: offsets, bits, resets, timing
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH

// register byte offsets on the wishbone slave
`define LPM_ADR_CTRL 32'h0000_0000
`define LPM_ADR_CLKMUX 32'h0000_0004
`define LPM_ADR_SOFTRST 32'h0000_0008
`define LPM_ADR_ANAPWR 32'h0000_000c
`define LPM_ADR_STATUS 32'h0000_0010
`define LPM_ADR_RTCCNT 32'h0000_0014
`define LPM_ADR_RTCMATCH 32'h0000_0018

// control register bits
`define LPM_CTRL_STANDBY_ARM 0
`define LPM_CTRL_REG_OFF 1
`define LPM_CTRL_MATCH_EN 2

// clock mux control bits
`define LPM_CLK_SEL_SLOW 0
`define LPM_CLK_LP_XTAL_EN 28
`define LPM_CLK_MAIN_OSC_EN 29

// status register bits
`define LPM_ST_MODE_LO 0
`define LPM_ST_CORE_SLEEP 2
`define LPM_ST_FLASH_RST 3
`define LPM_ST_REG_ON 4
`define LPM_ST_CLK_SLOW 5
`define LPM_ST_RTC_FLAG 6

// widths and reset values
`define LPM_NPERIPH 16
`define LPM_NANALOG 8
`define LPM_CNT_W 16
`define LPM_SOFTRST_RST 16'h0000
`define LPM_ANAPWR_RST 8'h00

// timing
`define LPM_CLK_PERIOD_NS 10
`define LPM_WAKE_SETTLE_NS 1000
`define LPM_REF_HZ 100000000
`define LPM_SLOW_HZ 32768

`endif

// file: src/lpm_pkg.sv
// types shared by the low power mode controller files
`default_nettype none
`include "lpm_cfg.svh"

package lpm_pkg;

  typedef enum logic [1:0] {
    LPM_NORMAL,
    LPM_STANDBY,
    LPM_WAKE,
    LPM_TIMEKEEP
  } lpm_mode_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } lpm_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } lpm_wb_rsp_t;

  typedef struct packed {
    logic coreClkEn;
    logic intCtrlClkEn;
    logic flashRst;
    logic mainCrystalEn;
    logic lpCrystalEn;
    logic rcOscEn;
    logic regulatorEn;
  } lpm_ctl_t;

  typedef struct packed {
    logic [`LPM_CNT_W-1:0] divCnt;
    logic selSlow;
  } lpm_mux_state_t;

  typedef struct packed {
    lpm_mode_t mode;
    logic coreSleep;
    logic standbyArm;
    logic matchEn;
    logic main_osc_enable_bit;
    logic lpXtalEn;
    logic clkSelSlow;
    logic [`LPM_NPERIPH-1:0] periphRst;
    logic [`LPM_NANALOG-1:0] anaPwrDn;
    logic [31:0] rtcCount;
    logic [31:0] rtcMatchVal;
    logic rtcFlag;
    logic [`LPM_CNT_W-1:0] waitCnt;
    logic ack;
    logic [31:0] rdata;
  } lpm_state_t;

endpackage
`default_nettype wire

// file: src/lpm_clk_mux.sv
// glitch-free subsystem clock selector built on a slow-rate enable divider
`timescale 1ns/10ps
`default_nettype none
`include "lpm_cfg.svh"

module lpm_clk_mux
  import lpm_pkg::*;
#(
  parameter int unsigned DivCount = `LPM_REF_HZ / `LPM_SLOW_HZ
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic selSlowReq,
  output logic clkEn,
  output logic slowTick,
  output logic selSlowAct
);

  lpm_mux_state_t st_ff;
  lpm_mux_state_t nxt_st;

  localparam logic [`LPM_CNT_W-1:0] DivLast = `LPM_CNT_W'(DivCount - 1);

  // ==========================================================
  // divider and select
  assign slowTick = (st_ff.divCnt == DivLast);

  always_comb
  begin
    nxt_st = st_ff;
    if (slowTick)
    begin
      nxt_st.divCnt = '0;
      // switch only on a slow period boundary: no runt enable pulse
      nxt_st.selSlow = selSlowReq;
    end
    else
    begin
      nxt_st.divCnt = st_ff.divCnt + `LPM_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign clkEn = st_ff.selSlow ? slowTick : 1'b1;
  assign selSlowAct = st_ff.selSlow;

  // ==========================================================
  // checks
  mux_switch_edge_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (st_ff.selSlow != $past(st_ff.selSlow)) |-> $past(slowTick))
    else $error("clock select changed off a slow boundary");

  slow_tick_gap_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    slowTick |=> !slowTick)
    else $error("slow tick on two adjacent cycles");

endmodule
`default_nettype wire

// file: src/lpm_power_ctrl.sv
// low power mode controller: mode sequencing, clock, reset and power controls
`timescale 1ns/10ps
`default_nettype none
`include "lpm_cfg.svh"

module lpm_power_ctrl
  import lpm_pkg::*;
#(
  parameter int unsigned WakeSettleNs = `LPM_WAKE_SETTLE_NS,
  parameter int unsigned SlowDiv = `LPM_REF_HZ / `LPM_SLOW_HZ
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire lpm_wb_req_t wbReq,
  output lpm_wb_rsp_t wbRsp,
  input wire logic sleepInstr,
  input wire logic irqProc,
  input wire logic irqFabric,
  input wire logic irqAfe,
  input wire logic power_up_request_n,
  input wire logic fabricRegOff,
  input wire logic mainSupplyOk,
  output lpm_ctl_t ctl,
  output logic [`LPM_NPERIPH-1:0] periphRst,
  output logic [`LPM_NANALOG-1:0] anaPwrDn,
  output logic subsysClkEn,
  output logic subsysClkSlow
);

  localparam int unsigned WakeCyc =
    (WakeSettleNs + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS;
  localparam logic [`LPM_CNT_W-1:0] WakeLast =
    `LPM_CNT_W'((WakeCyc > 1) ? WakeCyc - 1 : 0);

  lpm_state_t st_ff;
  lpm_state_t nxt_st;
  logic slowTick;
  logic clkSlowAct;
  logic anyIrq;
  logic regOffReq;
  logic wbReqNew;
  logic wbWrite;
  logic [31:0] statusWord;
  logic [31:0] wrData;

  // ==========================================================
  // clock selection
  lpm_clk_mux #(
    .DivCount(SlowDiv)
  ) u_mux (
    .ref_clk(ref_clk),
    .rstn(rstn),
    // standby forces the slow source; wake returns to firmware choice
    .selSlowReq(st_ff.clkSelSlow || (st_ff.mode == LPM_STANDBY)),
    .clkEn(subsysClkEn),
    .slowTick(slowTick),
    .selSlowAct(clkSlowAct)
  );

  function automatic logic [31:0] wbMerge(
    input logic [31:0] old,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        res[b*8 +: 8] = dat[b*8 +: 8];
    return res;
  endfunction

  // ==========================================================
  // event decode
  assign anyIrq = irqProc || irqFabric || irqAfe || st_ff.rtcFlag;
  assign wbReqNew = wbReq.cyc && wbReq.stb && !st_ff.ack;
  assign wbWrite = wbReqNew && wbReq.we;
  assign wrData = wbReq.dat;
  assign regOffReq = fabricRegOff || (wbWrite && wbReq.sel[0] &&
    (wbReq.adr == `LPM_ADR_CTRL) && wrData[`LPM_CTRL_REG_OFF]);

  always_comb
  begin
    statusWord = '0;
    statusWord[`LPM_ST_MODE_LO +: 2] = st_ff.mode;
    statusWord[`LPM_ST_CORE_SLEEP] = st_ff.coreSleep;
    statusWord[`LPM_ST_FLASH_RST] = ctl.flashRst;
    statusWord[`LPM_ST_REG_ON] = ctl.regulatorEn;
    statusWord[`LPM_ST_CLK_SLOW] = clkSlowAct;
    statusWord[`LPM_ST_RTC_FLAG] = st_ff.rtcFlag;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    logic [31:0] ctrlW;
    logic [31:0] clkW;
    ctrlW = '0;
    clkW = '0;
    nxt_st = st_ff;
    ctrlW[`LPM_CTRL_STANDBY_ARM] = st_ff.standbyArm;
    ctrlW[`LPM_CTRL_MATCH_EN] = st_ff.matchEn;
    clkW[`LPM_CLK_SEL_SLOW] = st_ff.clkSelSlow;
    clkW[`LPM_CLK_LP_XTAL_EN] = st_ff.lpXtalEn;
    clkW[`LPM_CLK_MAIN_OSC_EN] = st_ff.main_osc_enable_bit;

    // real-time counter runs in every mode, battery rail included
    if (slowTick)
      nxt_st.rtcCount = st_ff.rtcCount + 32'h0000_0001;

    // wishbone slave: one-cycle registered ack, write lands with the ack
    nxt_st.ack = wbReqNew;
    if (wbReqNew)
    begin
      case (wbReq.adr)
        `LPM_ADR_CTRL: nxt_st.rdata = ctrlW;
        `LPM_ADR_CLKMUX: nxt_st.rdata = clkW;
        `LPM_ADR_SOFTRST: nxt_st.rdata = 32'(st_ff.periphRst);
        `LPM_ADR_ANAPWR: nxt_st.rdata = 32'(st_ff.anaPwrDn);
        `LPM_ADR_STATUS: nxt_st.rdata = statusWord;
        `LPM_ADR_RTCCNT: nxt_st.rdata = st_ff.rtcCount;
        `LPM_ADR_RTCMATCH: nxt_st.rdata = st_ff.rtcMatchVal;
        default: nxt_st.rdata = '0;
      endcase
    end
    if (wbWrite)
    begin
      case (wbReq.adr)
        `LPM_ADR_CTRL:
        begin
          ctrlW = wbMerge(ctrlW, wrData, wbReq.sel);
          nxt_st.standbyArm = ctrlW[`LPM_CTRL_STANDBY_ARM];
          nxt_st.matchEn = ctrlW[`LPM_CTRL_MATCH_EN];
        end
        `LPM_ADR_CLKMUX:
        begin
          clkW = wbMerge(clkW, wrData, wbReq.sel);
          nxt_st.clkSelSlow = clkW[`LPM_CLK_SEL_SLOW];
          nxt_st.lpXtalEn = clkW[`LPM_CLK_LP_XTAL_EN];
          nxt_st.main_osc_enable_bit = clkW[`LPM_CLK_MAIN_OSC_EN];
        end
        `LPM_ADR_SOFTRST:
          nxt_st.periphRst = `LPM_NPERIPH'(wbMerge(32'(st_ff.periphRst),
            wrData, wbReq.sel));
        `LPM_ADR_ANAPWR:
          nxt_st.anaPwrDn = `LPM_NANALOG'(wbMerge(32'(st_ff.anaPwrDn),
            wrData, wbReq.sel));
        `LPM_ADR_STATUS:
          if (wbReq.sel[0] && wrData[`LPM_ST_RTC_FLAG])
            nxt_st.rtcFlag = 1'b0;
        `LPM_ADR_RTCCNT:
          nxt_st.rtcCount = wbMerge(st_ff.rtcCount, wrData, wbReq.sel);
        `LPM_ADR_RTCMATCH:
          nxt_st.rtcMatchVal = wbMerge(st_ff.rtcMatchVal, wrData,
            wbReq.sel);
        default:
          nxt_st.rdata = nxt_st.rdata;
      endcase
    end

    // match set placed after the clear so a coinciding match survives
    if (st_ff.matchEn && (st_ff.rtcCount == st_ff.rtcMatchVal) && slowTick)
      nxt_st.rtcFlag = 1'b1;

    // mode sequencing; of the bus registers only the standby arm bit is changed here (cleared on standby entry)
    case (st_ff.mode)
      LPM_NORMAL:
      begin
        if (regOffReq)
        begin
          nxt_st.mode = LPM_TIMEKEEP;
          nxt_st.coreSleep = 1'b0;
        end
        else if (sleepInstr && st_ff.standbyArm)
        begin
          nxt_st.mode = LPM_STANDBY;
          nxt_st.standbyArm = 1'b0;
        end
        else if (sleepInstr)
          nxt_st.coreSleep = 1'b1;
        else if (anyIrq)
          nxt_st.coreSleep = 1'b0;
      end
      LPM_STANDBY:
      begin
        if (regOffReq)
          nxt_st.mode = LPM_TIMEKEEP;
        else if (anyIrq)
        begin
          nxt_st.mode = LPM_WAKE;
          nxt_st.waitCnt = '0;
        end
      end
      LPM_WAKE:
      begin
        // hold the core until the flash and main clock have settled
        if (st_ff.waitCnt != WakeLast)
          nxt_st.waitCnt = st_ff.waitCnt + `LPM_CNT_W'(1);
        else if (clkSlowAct == st_ff.clkSelSlow)
          nxt_st.mode = LPM_NORMAL;
      end
      LPM_TIMEKEEP:
      begin
        if (mainSupplyOk && (st_ff.rtcFlag || !power_up_request_n))
        begin
          nxt_st.mode = LPM_WAKE;
          nxt_st.waitCnt = '0;
        end
      end
      default:
        nxt_st.mode = LPM_NORMAL;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      st_ff <= '0;
      st_ff.mode <= LPM_NORMAL;
      st_ff.main_osc_enable_bit <= 1'b1;
      st_ff.lpXtalEn <= 1'b1;
      st_ff.periphRst <= `LPM_SOFTRST_RST;
      st_ff.anaPwrDn <= `LPM_ANAPWR_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // ==========================================================
  // outputs
  always_comb
  begin
    ctl.coreClkEn = (st_ff.mode == LPM_NORMAL) && !st_ff.coreSleep;
    ctl.intCtrlClkEn = (st_ff.mode != LPM_TIMEKEEP);
    ctl.flashRst = (st_ff.mode == LPM_STANDBY) ||
      (st_ff.mode == LPM_TIMEKEEP);
    ctl.mainCrystalEn = st_ff.main_osc_enable_bit && (st_ff.mode != LPM_STANDBY) &&
      (st_ff.mode != LPM_TIMEKEEP);
    ctl.lpCrystalEn = st_ff.lpXtalEn;
    ctl.rcOscEn = 1'b1;
    ctl.regulatorEn = (st_ff.mode != LPM_TIMEKEEP);
  end

  assign periphRst = st_ff.periphRst;
  assign anaPwrDn = st_ff.anaPwrDn;
  assign subsysClkSlow = clkSlowAct;
  assign wbRsp.ack = st_ff.ack;
  assign wbRsp.dat = st_ff.rdata;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  core_sleep_gate_a: assert property (
    st_ff.coreSleep |-> !ctl.coreClkEn && ctl.intCtrlClkEn)
    else $error("core clock running while core sleeps");

  standby_state_a: assert property (
    (st_ff.mode == LPM_STANDBY) |->
      ctl.flashRst && !ctl.mainCrystalEn && !ctl.coreClkEn)
    else $error("standby outputs wrong");

  rc_osc_on_a: assert property (
    ctl.rcOscEn)
    else $error("rc oscillator disabled");

  regulator_wake_a: assert property (
    (st_ff.mode == LPM_TIMEKEEP && mainSupplyOk && !power_up_request_n)
      |=> ctl.regulatorEn ##1 ctl.regulatorEn)
    else $error("regulator did not switch on");

  regulator_off_a: assert property (
    (st_ff.mode == LPM_NORMAL && fabricRegOff) |=> !ctl.regulatorEn)
    else $error("regulator did not switch off");

  standby_irq_wake_a: assert property (
    (st_ff.mode == LPM_STANDBY && irqAfe && !fabricRegOff)
      |=> (st_ff.mode == LPM_WAKE) && !ctl.coreClkEn)
    else $error("interrupt failed to leave standby");

  wake_restore_a: assert property (
    (st_ff.mode == LPM_WAKE) |->
      !ctl.flashRst && !ctl.coreClkEn && (ctl.mainCrystalEn == st_ff.main_osc_enable_bit))
    else $error("wake released core before flash and clock");

  soft_reset_write_a: assert property (
    (wbRsp.ack && wbReq.we && wbReq.sel == 4'hf &&
      wbReq.adr == `LPM_ADR_SOFTRST)
      |-> periphRst == wbReq.dat[`LPM_NPERIPH-1:0])
    else $error("peripheral reset not as written");

  normal_running_a: assert property (
    (st_ff.mode == LPM_NORMAL) |-> ctl.regulatorEn && !ctl.flashRst)
    else $error("normal mode not fully running");

  timekeep_exit_a: assert property (
    (st_ff.mode == LPM_TIMEKEEP && !mainSupplyOk) |=>
      (st_ff.mode == LPM_TIMEKEEP))
    else $error("left time keeping without supply");

endmodule
`default_nettype wire

// file: testbench/lpm_fabric_model.sv
// fabric system controller model: wake interrupt and regulator-off request
`timescale 1ns/10ps
`default_nettype none

module lpm_fabric_model
#(
  parameter int unsigned IrqDelay = 3
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic irqGo,
  input wire logic offGo,
  input wire logic coreClkEn,
  output logic irqFabric,
  output logic fabricRegOff
);
  int unsigned cnt;

  // =====================================================
  // request logic
  // the interrupt stays a level until the core runs again, like real fabric
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      cnt <= 0;
      irqFabric <= 1'b0;
      fabricRegOff <= 1'b0;
    end
    else
    begin
      fabricRegOff <= offGo;
      if (irqGo)
        cnt <= IrqDelay;
      else if (cnt > 0)
        cnt <= cnt - 1;
      if (cnt == 1)
        irqFabric <= 1'b1;
      else if (irqFabric && coreClkEn)
        irqFabric <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// file: testbench/low_power_mode_control_tb_top.sv
// self-checking bench for the low power mode controller
`timescale 1ns/10ps
`default_nettype none
`include "lpm_cfg.svh"

`define CHK(nm, ex, gt) \
  begin check_count++; if ((gt) !== (ex)) begin err_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end

module low_power_mode_control_tb_top
  import lpm_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn;
  lpm_wb_req_t req;
  lpm_wb_rsp_t rsp;
  logic sleepInstr, irqProc, irqAfe, puReqN, supOk, irqGo, offGo;
  logic irqFabric, fabricRegOff, subsysClkEn, subsysClkSlow;
  lpm_ctl_t ctl;
  logic [`LPM_NPERIPH-1:0] periphRst;
  logic [`LPM_NANALOG-1:0] anaPwrDn;
  logic [31:0] q;
  int err_count = 0;
  int check_count = 0;
  int tickCnt;

  always #5 ref_clk = ~ref_clk;

  lpm_power_ctrl #(.WakeSettleNs(50), .SlowDiv(8)) lpm_power_ctrl_i (
    .ref_clk(ref_clk), .rstn(rstn), .wbReq(req), .wbRsp(rsp),
    .sleepInstr(sleepInstr), .irqProc(irqProc), .irqFabric(irqFabric),
    .irqAfe(irqAfe), .power_up_request_n(puReqN),
    .fabricRegOff(fabricRegOff), .mainSupplyOk(supOk), .ctl(ctl),
    .periphRst(periphRst), .anaPwrDn(anaPwrDn),
    .subsysClkEn(subsysClkEn), .subsysClkSlow(subsysClkSlow));

  lpm_fabric_model lpm_fabric_model_i (
    .ref_clk(ref_clk), .rstn(rstn), .irqGo(irqGo), .offGo(offGo),
    .coreClkEn(ctl.coreClkEn), .irqFabric(irqFabric),
    .fabricRegOff(fabricRegOff));

  // =====================================================
  // closing and bus tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // values read right after an edge are those sampled at that edge
  task automatic wb(input logic w, input logic [31:0] a, d,
                    output logic [31:0] rd);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    @(posedge ref_clk);
    while (rsp.ack !== 1'b1)
    begin
      if (n++ == 50)
      begin
        err_count++;
        complete_run();
      end
      @(posedge ref_clk);
    end
    rd = rsp.dat;
    req <= '0;
    @(posedge ref_clk);
  endtask

  task automatic poll(input logic [31:0] a, m, v);
    logic [31:0] rd;
    int n;
    n = 0;
    rd = ~v;
    while ((rd & m) !== v)
    begin
      if (n++ == 300)
      begin
        err_count++;
        complete_run();
      end
      wb(1'b0, a, 32'h0, rd);
    end
  endtask

  task automatic pulse_sleep();
    sleepInstr <= 1'b1;
    @(posedge ref_clk);
    sleepInstr <= 1'b0;
    @(posedge ref_clk);
  endtask

  // =====================================================
  // main sequence
  initial
  begin
    req = '0;
    {sleepInstr, irqProc, irqAfe, irqGo, offGo, rstn} = '0;
    puReqN = 1'b1;
    supOk = 1'b1;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK("ctl", 7'h6f, ctl)
    wb(1'b0, `LPM_ADR_CLKMUX, 32'h0, q);
    `CHK("clkmux", 32'h3000_0000, q)
    wb(1'b1, `LPM_ADR_SOFTRST, 32'h0000_a5c3, q);
    wb(1'b1, `LPM_ADR_ANAPWR, 32'h0000_005a, q);
    wb(1'b1, 32'h0000_0020, 32'hffff_ffff, q);
    `CHK("periphRst", 16'ha5c3, periphRst)
    `CHK("anaPwrDn", 8'h5a, anaPwrDn)
    wb(1'b0, 32'h0000_0020, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    wb(1'b1, `LPM_ADR_CLKMUX, 32'h1000_0000, q);
    `CHK("main_crystal", 1'b0, ctl.mainCrystalEn)
    `CHK("low_power_crystal", 1'b1, ctl.lpCrystalEn)
    wb(1'b1, `LPM_ADR_CLKMUX, 32'h3000_0000, q);
    // plain sleep: core gated, interrupt controller still clocked
    pulse_sleep();
    `CHK("sleep", 2'b01, {ctl.coreClkEn, ctl.intCtrlClkEn})
    irqProc <= 1'b1;
    @(posedge ref_clk);
    irqProc <= 1'b0;
    @(posedge ref_clk);
    `CHK("irqWake", 1'b1, ctl.coreClkEn)
    // standby entry and fabric wake
    wb(1'b1, `LPM_ADR_CTRL, 32'h1, q);
    pulse_sleep();
    `CHK("standby", 4'h5, {ctl.coreClkEn, ctl.flashRst, ctl.mainCrystalEn,
      ctl.intCtrlClkEn})
    poll(`LPM_ADR_STATUS, 32'h23, 32'h21);
    irqGo <= 1'b1;
    @(posedge ref_clk);
    irqGo <= 1'b0;
    poll(`LPM_ADR_STATUS, 32'h3, 32'h2);
    `CHK("wake", 3'b011,
      {ctl.flashRst, ctl.mainCrystalEn, ctl.regulatorEn})
    poll(`LPM_ADR_STATUS, 32'h3, 32'h0);
    `CHK("normal", 2'b10, {ctl.coreClkEn, subsysClkSlow})
    wb(1'b0, `LPM_ADR_SOFTRST, 32'h0, q);
    `CHK("retain", 32'h0000_a5c3, q)
    // time keeping by fabric, exit only once supplies are back
    offGo <= 1'b1;
    @(posedge ref_clk);
    offGo <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("regOff", 2'b01, {ctl.regulatorEn, ctl.rcOscEn})
    supOk <= 1'b0;
    puReqN <= 1'b0;
    repeat (8) @(posedge ref_clk);
    wb(1'b0, `LPM_ADR_STATUS, 32'h0, q);
    `CHK("keep", 2'h3, q[1:0])
    supOk <= 1'b1;
    poll(`LPM_ADR_STATUS, 32'h3, 32'h0);
    `CHK("regOn", 1'b1, ctl.regulatorEn)
    puReqN <= 1'b1;
    // firmware off, then counter match wakes from time keeping
    wb(1'b1, `LPM_ADR_RTCCNT, 32'h0, q);
    wb(1'b1, `LPM_ADR_RTCMATCH, 32'h0000_0010, q);
    wb(1'b1, `LPM_ADR_CTRL, 32'h6, q);
    `CHK("fwOff", 1'b0, ctl.regulatorEn)
    poll(`LPM_ADR_STATUS, 32'h53, 32'h50);
    wb(1'b1, `LPM_ADR_STATUS, 32'h40, q);
    wb(1'b0, `LPM_ADR_STATUS, 32'h0, q);
    `CHK("flagClr", 1'b0, q[6])
    // counter match wakes a sleeping core
    wb(1'b1, `LPM_ADR_RTCCNT, 32'h0, q);
    wb(1'b1, `LPM_ADR_RTCMATCH, 32'h0000_0014, q);
    pulse_sleep();
    `CHK("rtcSleep", 1'b0, ctl.coreClkEn)
    poll(`LPM_ADR_STATUS, 32'h40, 32'h40);
    `CHK("rtcWake", 1'b1, ctl.coreClkEn)
    // standby again: slow enable pulses, analog front end wakes it
    wb(1'b1, `LPM_ADR_CTRL, 32'h1, q);
    wb(1'b1, `LPM_ADR_STATUS, 32'h40, q);
    pulse_sleep();
    poll(`LPM_ADR_STATUS, 32'h23, 32'h21);
    `CHK("lpStby", 1'b1, ctl.lpCrystalEn)
    // 16 cycles on the slow source hold exactly two enable pulses
    tickCnt = 0;
    repeat (16)
    begin
      @(posedge ref_clk);
      tickCnt += int'(subsysClkEn);
    end
    `CHK("slowEn", 2, tickCnt)
    irqAfe <= 1'b1;
    @(posedge ref_clk);
    irqAfe <= 1'b0;
    poll(`LPM_ADR_STATUS, 32'h23, 32'h0);
    `CHK("afeWake", 2'b11, {ctl.coreClkEn, subsysClkEn})
    complete_run();
  end
endmodule

`default_nettype wire
